// [verilog/bm_fifo_pkg.sv]
package bm_fifo_pkg;

  // ****************************************************************
  // widths and depths
  // ****************************************************************
  localparam int WORD_W      = 18;
  localparam int HALF_W      = 9;
  localparam int DEPTH_DEF   = 16;
  localparam int SYNC_STAGES = 2;

  // ****************************************************************
  // fall-through timing
  // ****************************************************************
  localparam logic [1:0] FT_TRANSITIONS = 2'h3;

  // ****************************************************************
  // parity bit positions for parallel offset load
  // ****************************************************************
  localparam int PAR_BIT  = 8;
  localparam int NOPAR_HI = 15;

  // ****************************************************************
  // default offset pairs, index {load, sel1, sel0}
  // ****************************************************************
  localparam int NUM_DEF_OFFS = 8;
  localparam logic [NUM_DEF_OFFS-1:0][3:0] DEF_AE_OFFS = {
    4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
  localparam logic [NUM_DEF_OFFS-1:0][3:0] DEF_AF_OFFS = {
    4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};

endpackage : bm_fifo_pkg

// [verilog/bm_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

// ******************************************************************
// word store with rewind
// ******************************************************************
module bm_word_store
  import bm_fifo_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = DEPTH_DEF,
  parameter int CNT_W = $clog2(DEPTH) + 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_clear,
  input  wire logic             i_push_valid,
  output logic                  o_push_ready,
  input  wire logic [WIDTH-1:0] i_push_data,
  output logic                  o_pop_valid,
  input  wire logic             i_pop_ready,
  output logic      [WIDTH-1:0] o_pop_data,
  output logic      [WIDTH-1:0] o_first_data,
  input  wire logic             i_rewind,
  output logic      [CNT_W-1:0] o_count
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("depth must be a power of two and at least two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CNT_W-1:0] wr_ptr_ff;
  logic [CNT_W-1:0] rd_ptr_ff;
  logic             push;
  logic             pop;

  assign o_count      = wr_ptr_ff - rd_ptr_ff;
  assign o_push_ready = (o_count != CNT_W'(DEPTH));
  assign o_pop_valid  = (o_count != '0);
  assign o_pop_data   = mem[rd_ptr_ff[AW-1:0]];
  assign o_first_data = mem[0];
  assign push         = i_push_valid & o_push_ready;
  assign pop          = i_pop_ready & (o_pop_valid | i_rewind);

  // storage, no reset needed on the array
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_ff[AW-1:0]] <= i_push_data;
    end
  end

  // write pointer
  always_ff @(posedge i_clk) begin
    if (i_clear) begin
      wr_ptr_ff <= '0;
    end else if (push) begin
      wr_ptr_ff <= wr_ptr_ff + CNT_W'(1);
    end
  end

  // read pointer; rewind with a same-edge pop skips slot zero
  always_ff @(posedge i_clk) begin
    if (i_clear) begin
      rd_ptr_ff <= '0;
    end else if (i_rewind) begin
      rd_ptr_ff <= pop ? CNT_W'(1) : '0;
    end else if (pop) begin
      rd_ptr_ff <= rd_ptr_ff + CNT_W'(1);
    end
  end

endmodule : bm_word_store

// ******************************************************************
// bus matching dual-clock fifo
// ******************************************************************
module dual_clock_bus_matching_fifo
  import bm_fifo_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_wr_clk,
  input  wire logic              i_rd_clk,
  input  wire logic              i_write_strobe_n,
  input  wire logic              i_read_strobe_n,
  input  wire logic [WORD_W-1:0] i_data_in,
  input  wire logic              i_out_en_n,
  input  wire logic              i_in_width_sel,
  input  wire logic              i_out_width_sel,
  input  wire logic              i_fallthrough_sel_serial_in,
  input  wire logic              i_offset_default_sel0,
  input  wire logic              i_offset_default_sel1,
  input  wire logic              i_offset_load_n,
  input  wire logic              i_serial_load_en_n,
  input  wire logic              i_flag_timing_sel,
  input  wire logic              i_reread_n,
  input  wire logic              i_reread_latency_sel,
  input  wire logic              i_full_reset_n,
  input  wire logic              i_soft_reset_n,
  input  wire logic              i_byte_order_sel,
  input  wire logic              i_parity_place_sel,
  output logic      [WORD_W-1:0] o_data_out,
  output logic                   o_data_oe_n,
  output logic                   o_empty_flag_n,
  output logic                   o_full_flag_n,
  output logic                   o_half_full_n,
  output logic                   o_almost_empty_n,
  output logic                   o_almost_full_n
);
  localparam int CNT_W = $clog2(DEPTH) + 1;
  localparam int OFF_W = CNT_W;
  localparam int PIN_W = WORD_W + 19;

  initial begin
    if (DEPTH < NUM_DEF_OFFS) begin
      $error("depth too small for the default offsets");
    end
  end

  // ****************************************************************
  // pin synchronisers; clocks arrive as pins and are edge detected
  // ****************************************************************
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1_ff;
  logic [PIN_W-1:0] sync2_ff;
  logic             wclk_prev_ff;
  logic             rclk_prev_ff;

  assign pin_raw = {i_wr_clk, i_rd_clk, i_write_strobe_n, i_read_strobe_n,
                    i_out_en_n, i_in_width_sel, i_out_width_sel,
                    i_fallthrough_sel_serial_in, i_offset_default_sel0,
                    i_offset_default_sel1, i_offset_load_n, i_serial_load_en_n,
                    i_flag_timing_sel, i_reread_n, i_reread_latency_sel,
                    i_full_reset_n, i_soft_reset_n, i_byte_order_sel,
                    i_parity_place_sel, i_data_in};

  // data travels with the clock pin so the edge samples aligned data
  always_ff @(posedge i_clk) begin
    sync1_ff <= pin_raw;
    sync2_ff <= sync1_ff;
  end

  logic              s_wclk, s_rclk, s_ws_n, s_rs_n, s_oe_n, s_in9, s_out9, s_fsi;
  logic              s_sel0, s_sel1, s_load_n, s_ser_n, s_fsync, s_reread_n, s_rlat;
  logic              s_frst_n, s_srst_n, s_order, s_par;
  logic [WORD_W-1:0] s_data;

  assign {s_wclk, s_rclk, s_ws_n, s_rs_n, s_oe_n, s_in9, s_out9, s_fsi, s_sel0,
          s_sel1, s_load_n, s_ser_n, s_fsync, s_reread_n, s_rlat, s_frst_n, s_srst_n,
          s_order, s_par, s_data} = sync2_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wclk_prev_ff <= 1'b0;
      rclk_prev_ff <= 1'b0;
    end else begin
      wclk_prev_ff <= s_wclk;
      rclk_prev_ff <= s_rclk;
    end
  end

  // both clock pins are only sampled, so any ratio or a stopped clock works
  logic wr_rise, rd_rise, rd_trans, full_rst, clear;
  assign wr_rise  = s_wclk & ~wclk_prev_ff;
  assign rd_rise  = s_rclk & ~rclk_prev_ff;
  assign rd_trans = s_rclk ^ rclk_prev_ff;
  assign full_rst = ~i_rst_n | ~s_frst_n;
  assign clear    = full_rst | ~s_srst_n;

  // ****************************************************************
  // modes latched during full reset
  // ****************************************************************
  logic in9_ff, out9_ff, ft_mode_ff, flag_sync_ff, rlat_norm_ff;
  logic little_ff, ipar_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      in9_ff       <= 1'b0;
      out9_ff      <= 1'b0;
      ft_mode_ff   <= 1'b0;
      flag_sync_ff <= 1'b0;
      rlat_norm_ff <= 1'b0;
      little_ff    <= 1'b0;
      ipar_ff      <= 1'b0;
    end else if (!s_frst_n) begin
      in9_ff       <= s_in9;
      out9_ff      <= s_out9;
      ft_mode_ff   <= s_fsi;
      flag_sync_ff <= s_fsync;
      rlat_norm_ff <= s_rlat;
      little_ff    <= s_order;
      ipar_ff      <= s_par;
    end
  end

  // ****************************************************************
  // write side: packing and word store
  // ****************************************************************
  logic              wr_req, push_ready, push_valid, pack_have_ff;
  logic [HALF_W-1:0] pack_ff;
  logic [WORD_W-1:0] push_word;

  assign wr_req     = wr_rise & ~s_ws_n & s_load_n;
  assign push_valid = wr_req & (~in9_ff | pack_have_ff);
  assign push_word  = !in9_ff ? s_data :
                      little_ff ? {s_data[HALF_W-1:0], pack_ff} :
                                  {pack_ff, s_data[HALF_W-1:0]};

  // a lone byte waits here; it is dropped if the store is full
  always_ff @(posedge i_clk) begin
    if (clear) begin
      pack_have_ff <= 1'b0;
      pack_ff      <= '0;
    end else if (wr_req && in9_ff && push_ready) begin
      pack_have_ff <= ~pack_have_ff;
      pack_ff      <= s_data[HALF_W-1:0];
    end
  end

  logic              pop_valid, pop_ready, rewind;
  logic [WORD_W-1:0] pop_word, first_word;
  logic [CNT_W-1:0]  count;

  bm_word_store #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH),
    .CNT_W (CNT_W)
  ) u_store (
    .i_clk        (i_clk),
    .i_clear      (clear),
    .i_push_valid (push_valid),
    .o_push_ready (push_ready),
    .i_push_data  (push_word),
    .o_pop_valid  (pop_valid),
    .i_pop_ready  (pop_ready),
    .o_pop_data   (pop_word),
    .o_first_data (first_word),
    .i_rewind     (rewind),
    .o_count      (count)
  );

  // ****************************************************************
  // read side: output register, halves and fall-through
  // ****************************************************************
  logic              out_valid_ff, half_pend_ff;
  logic [HALF_W-1:0] half_ff;
  logic [WORD_W-1:0] q_ff;
  logic [1:0]        ft_cnt_ff;
  logic              rd_req, rew_req, auto_load, zero_lat, load_word;
  logic [WORD_W-1:0] load_src;
  logic [HALF_W-1:0] first_half, second_half;
  logic [OFF_W-1:0]  ae_off_ff, af_off_ff;
  logic              wr_sel_ff, rd_sel_ff;

  assign rd_req    = rd_rise & ~s_rs_n & s_load_n;
  assign rew_req   = rd_rise & ~s_reread_n;
  assign zero_lat  = rew_req & ~rlat_norm_ff;
  assign auto_load = ft_mode_ff & ~out_valid_ff & pop_valid &
                     (ft_cnt_ff == FT_TRANSITIONS - 2'h1) & rd_trans;
  assign load_word = zero_lat | auto_load | (rd_req & ~half_pend_ff & pop_valid);
  assign pop_ready = load_word;
  assign rewind    = rew_req;
  assign load_src  = zero_lat ? first_word : pop_word;
  assign first_half  = little_ff ? load_src[HALF_W-1:0] : load_src[WORD_W-1:HALF_W];
  assign second_half = little_ff ? load_src[WORD_W-1:HALF_W] : load_src[HALF_W-1:0];

  // count read clock transitions while a first word waits
  always_ff @(posedge i_clk) begin
    if (clear || out_valid_ff || !pop_valid || load_word) begin
      ft_cnt_ff <= '0;
    end else if (rd_trans && ft_cnt_ff != FT_TRANSITIONS) begin
      ft_cnt_ff <= ft_cnt_ff + 2'h1;
    end
  end

  // output register; offset readback shares it
  always_ff @(posedge i_clk) begin
    if (clear) begin
      q_ff         <= '0;
      out_valid_ff <= 1'b0;
      half_pend_ff <= 1'b0;
      half_ff      <= '0;
    end else if (load_word) begin
      q_ff         <= out9_ff ? {{(WORD_W-HALF_W){1'b0}}, first_half} : load_src;
      half_ff      <= second_half;
      half_pend_ff <= out9_ff;
      out_valid_ff <= 1'b1;
    end else if (rew_req) begin
      half_pend_ff <= 1'b0;
      out_valid_ff <= ~ft_mode_ff & out_valid_ff;
    end else if (rd_req && half_pend_ff) begin
      q_ff         <= {{(WORD_W-HALF_W){1'b0}}, half_ff};
      half_pend_ff <= 1'b0;
    end else if (rd_req) begin
      out_valid_ff <= 1'b0;
    end else if (rd_rise && !s_rs_n && !s_load_n) begin
      q_ff <= rd_sel_ff ? WORD_W'(af_off_ff) : WORD_W'(ae_off_ff);
    end
  end

  // ****************************************************************
  // offset registers
  // ****************************************************************
  logic [2:0]        def_idx;
  logic [WORD_W-1:0] par_val;

  assign def_idx = {s_load_n, s_sel1, s_sel0};
  assign par_val = (!in9_ff && ipar_ff) ?
                   {2'h0, s_data[WORD_W-2:PAR_BIT+1], s_data[PAR_BIT-1:0]} :
                   {2'h0, s_data[NOPAR_HI:0]};

  always_ff @(posedge i_clk) begin
    if (full_rst) begin
      ae_off_ff <= OFF_W'(DEF_AE_OFFS[def_idx]);
      af_off_ff <= OFF_W'(DEF_AF_OFFS[def_idx]);
      wr_sel_ff <= 1'b0;
    end else if (s_load_n) begin
      wr_sel_ff <= 1'b0;
    end else if (wr_rise && !s_ser_n) begin
      {af_off_ff, ae_off_ff} <= {af_off_ff[OFF_W-2:0], ae_off_ff, s_fsi};
    end else if (wr_rise && !s_ws_n) begin
      if (wr_sel_ff) begin
        af_off_ff <= par_val[OFF_W-1:0];
      end else begin
        ae_off_ff <= par_val[OFF_W-1:0];
      end
      wr_sel_ff <= ~wr_sel_ff;
    end
  end

  // readback alternates between the two offsets
  always_ff @(posedge i_clk) begin
    if (full_rst || s_load_n) begin
      rd_sel_ff <= 1'b0;
    end else if (rd_rise && !s_rs_n) begin
      rd_sel_ff <= ~rd_sel_ff;
    end
  end

  // ****************************************************************
  // flags; almost empty and almost full evaluated one cycle after the edge so the count is fresh, half full every cycle
  // ****************************************************************
  logic wr_evt_ff, rd_evt_ff, ae_now, af_now, ae_n_ff, af_n_ff, half_n_ff;

  assign ae_now = (count <= ae_off_ff);
  assign af_now = (count >= CNT_W'(DEPTH) - af_off_ff);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_evt_ff <= 1'b0;
      rd_evt_ff <= 1'b0;
    end else begin
      wr_evt_ff <= wr_rise;
      rd_evt_ff <= rd_rise;
    end
  end

  // almost empty: sync on read only; async asserts on read, clears on write
  always_ff @(posedge i_clk) begin
    if (full_rst) begin
      ae_n_ff <= 1'b0;
    end else if (!s_srst_n) begin
      ae_n_ff <= 1'b0;
    end else if (flag_sync_ff) begin
      if (rd_evt_ff) ae_n_ff <= ~ae_now;
    end else if (rd_evt_ff && ae_now) begin
      ae_n_ff <= 1'b0;
    end else if (wr_evt_ff && !ae_now) begin
      ae_n_ff <= 1'b1;
    end
  end

  // almost full mirrors the above with the clocks swapped
  always_ff @(posedge i_clk) begin
    if (clear) begin
      af_n_ff <= 1'b1;
    end else if (flag_sync_ff) begin
      if (wr_evt_ff) af_n_ff <= ~af_now;
    end else if (wr_evt_ff && af_now) begin
      af_n_ff <= 1'b0;
    end else if (rd_evt_ff && !af_now) begin
      af_n_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (clear) begin
      half_n_ff <= 1'b1;
    end else begin
      half_n_ff <= ~(count > CNT_W'(DEPTH / 2));
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_data_out       = q_ff;
  assign o_data_oe_n      = s_oe_n;
  assign o_empty_flag_n   = ft_mode_ff ? ~out_valid_ff :
                                         (pop_valid | half_pend_ff);
  assign o_full_flag_n    = ft_mode_ff ? ~push_ready : push_ready;
  assign o_half_full_n    = half_n_ff;
  assign o_almost_empty_n = ae_n_ff;
  assign o_almost_full_n  = af_n_ff;

endmodule : dual_clock_bus_matching_fifo

`default_nettype wire

// [tb/bm_fifo_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module bm_fifo_checker
  import bm_fifo_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
) (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_wr_clk,
  input wire logic              i_rd_clk,
  input wire logic              i_out_en_n,
  input wire logic              i_fallthrough_sel_serial_in,
  input wire logic              i_flag_timing_sel,
  input wire logic              i_full_reset_n,
  input wire logic              i_soft_reset_n,
  input wire logic [WORD_W-1:0] o_data_out,
  input wire logic              o_data_oe_n,
  input wire logic              o_empty_flag_n,
  input wire logic              o_full_flag_n,
  input wire logic              o_half_full_n,
  input wire logic              o_almost_empty_n,
  input wire logic              o_almost_full_n
);
  // ******
  // recent pin activity
  // ******
  logic [7:0] wr_hist_ff;
  logic [7:0] rd_hist_ff;
  logic [7:0] rs_hist_ff;
  logic       wr_act;
  logic       rd_act;
  logic       rs_act;

  // eight samples cover the two sync flops plus flag pipeline
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_hist_ff <= 8'h00;
      rd_hist_ff <= 8'h00;
      rs_hist_ff <= 8'h00;
    end else begin
      wr_hist_ff <= {wr_hist_ff[6:0], i_wr_clk};
      rd_hist_ff <= {rd_hist_ff[6:0], i_rd_clk};
      rs_hist_ff <= {rs_hist_ff[6:0], i_full_reset_n & i_soft_reset_n};
    end
  end

  // a clock pin that toggled inside the window counts as active; reset counts if low in any sample
  assign wr_act = (wr_hist_ff != 8'h00) && (wr_hist_ff != 8'hff);
  assign rd_act = (rd_hist_ff != 8'h00) && (rd_hist_ff != 8'hff);
  assign rs_act = (rs_hist_ff != 8'hff);

  // ******
  // properties
  // ******
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_oe_follows_pin: assert property ($past(i_rst_n, 2) |-> o_data_oe_n == $past(i_out_en_n, 2))
    else $error("output enable off its pin");
  a_reset_level_flags: assert property ((!i_full_reset_n) [*8] |-> o_data_out == '0 && !o_almost_empty_n && o_almost_full_n && o_half_full_n)
    else $error("full reset state wrong");
  a_reset_mode_flags: assert property ((!i_full_reset_n) [*8] |-> o_empty_flag_n == i_fallthrough_sel_serial_in && o_full_flag_n != i_fallthrough_sel_serial_in)
    else $error("full reset mode flags wrong");
  a_soft_flags_clear: assert property ((i_full_reset_n && !i_soft_reset_n) [*8] |-> !o_almost_empty_n && o_half_full_n && o_almost_full_n)
    else $error("partial reset flags wrong");
  a_out_moves_read: assert property ($changed(o_data_out) |-> rd_act || rs_act)
    else $error("data out moved without read clock");
  a_empty_on_read: assert property ($fell(o_empty_flag_n) |-> rd_act || rs_act)
    else $error("first flag fell without read clock");
  a_half_on_write: assert property ($fell(o_half_full_n) |-> wr_act)
    else $error("half flag fell without write clock");
  a_ae_drop_read: assert property ($fell(o_almost_empty_n) |-> rd_act || rs_act)
    else $error("almost empty fell without read clock");
  a_af_drop_write: assert property ($fell(o_almost_full_n) |-> wr_act)
    else $error("almost full fell without write clock");
  a_ae_sync_read: assert property (i_flag_timing_sel && $changed(o_almost_empty_n) |-> rd_act || rs_act)
    else $error("synchronous almost empty moved off read clock");

endmodule : bm_fifo_checker

bind dual_clock_bus_matching_fifo bm_fifo_checker #(.DEPTH(DEPTH)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_clk(i_wr_clk), .i_rd_clk(i_rd_clk),
  .i_out_en_n(i_out_en_n), .i_fallthrough_sel_serial_in(i_fallthrough_sel_serial_in),
  .i_flag_timing_sel(i_flag_timing_sel), .i_full_reset_n(i_full_reset_n),
  .i_soft_reset_n(i_soft_reset_n), .o_data_out(o_data_out), .o_data_oe_n(o_data_oe_n),
  .o_empty_flag_n(o_empty_flag_n), .o_full_flag_n(o_full_flag_n),
  .o_half_full_n(o_half_full_n), .o_almost_empty_n(o_almost_empty_n),
  .o_almost_full_n(o_almost_full_n));

`default_nettype wire

// [tb/bm_fifo_peer.sv]
`timescale 1ns/1ps
`default_nettype none

module bm_fifo_peer
  import bm_fifo_pkg::*;
(
  input  wire logic              i_clk,
  output logic                   o_wr_clk,
  output logic                   o_rd_clk,
  output logic                   o_write_strobe_n,
  output logic                   o_read_strobe_n,
  output logic                   o_reread_n,
  output logic      [WORD_W-1:0] o_data_in
);
  // clocks stand still low between transfers
  initial begin
    o_wr_clk         = 1'b0;
    o_rd_clk         = 1'b0;
    o_write_strobe_n = 1'b1;
    o_read_strobe_n  = 1'b1;
    o_reread_n       = 1'b1;
    o_data_in        = '0;
  end

  // one write clock period; data inverted once held long enough
  task automatic wr_cycle(input logic stb_n, input logic [WORD_W-1:0] d, input int ph);
    @(posedge i_clk);
    o_write_strobe_n <= stb_n;
    o_data_in        <= d;
    repeat (ph) @(posedge i_clk);
    o_wr_clk <= 1'b1;
    repeat (ph) @(posedge i_clk);
    o_wr_clk         <= 1'b0;
    o_write_strobe_n <= 1'b1;
    o_data_in        <= ~d;
    repeat (ph) @(posedge i_clk);
  endtask : wr_cycle

  // one read clock period, strobe and rewind held across the rise
  task automatic rd_cycle(input logic stb_n, input logic rr_n, input int ph);
    @(posedge i_clk);
    o_read_strobe_n <= stb_n;
    o_reread_n      <= rr_n;
    repeat (ph) @(posedge i_clk);
    o_rd_clk <= 1'b1;
    repeat (ph) @(posedge i_clk);
    o_rd_clk        <= 1'b0;
    o_read_strobe_n <= 1'b1;
    o_reread_n      <= 1'b1;
    repeat (ph) @(posedge i_clk);
  endtask : rd_cycle

endmodule : bm_fifo_peer

`default_nettype wire

// [tb/dual_clock_bus_matching_fifo_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module dual_clock_bus_matching_fifo_bench;
  import bm_fifo_pkg::*;
  localparam int               WP  = 4; // writer phase in system clocks
  localparam int               RP  = 5; // slower reader, no ratio to writer
  localparam logic [WORD_W-1:0] W18 = 18'h2b3c5;
  localparam logic [8:0]        BA  = 9'h1a5;
  localparam logic [8:0]        BB  = 9'h0c3;
  localparam logic [9:0]        SER = {5'h06, 5'h02};
  logic clk, rst_n, wclk, rclk, wstb_n, rstb_n, rr_n, oe_in_n, in9, out9, ft_si;
  logic sel0, sel1, load_n, ser_n, flsync, full_rst_n, soft_rst_n, order, rlat;
  logic oe_n, empty_n, full_n, half_n, aempty_n, afull_n;
  logic [WORD_W-1:0] din;
  logic [WORD_W-1:0] dout;
  int                miscompares;
  int                check_count;

  bm_fifo_peer u_peer (.i_clk(clk), .o_wr_clk(wclk), .o_rd_clk(rclk),
    .o_write_strobe_n(wstb_n), .o_read_strobe_n(rstb_n), .o_reread_n(rr_n), .o_data_in(din));

  dual_clock_bus_matching_fifo #(.DEPTH(DEPTH_DEF)) u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_wr_clk(wclk), .i_rd_clk(rclk),
    .i_write_strobe_n(wstb_n), .i_read_strobe_n(rstb_n), .i_data_in(din),
    .i_out_en_n(oe_in_n), .i_in_width_sel(in9), .i_out_width_sel(out9),
    .i_fallthrough_sel_serial_in(ft_si), .i_offset_default_sel0(sel0),
    .i_offset_default_sel1(sel1), .i_offset_load_n(load_n), .i_serial_load_en_n(ser_n),
    .i_flag_timing_sel(flsync), .i_reread_n(rr_n), .i_reread_latency_sel(rlat),
    .i_full_reset_n(full_rst_n), .i_soft_reset_n(soft_rst_n), .i_byte_order_sel(order),
    .i_parity_place_sel(1'b0), .o_data_out(dout), .o_data_oe_n(oe_n),
    .o_empty_flag_n(empty_n), .o_full_flag_n(full_n), .o_half_full_n(half_n),
    .o_almost_empty_n(aempty_n), .o_almost_full_n(afull_n));

  always #2 clk = ~clk;

  // ******
  // helpers
  // ******
  task automatic chk_word(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_flag(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_flag

  function automatic logic [WORD_W-1:0] pat(input int i);
    return WORD_W'(32'h2a5a5 ^ (i * 32'h1247));
  endfunction : pat

  task automatic wr(input logic [WORD_W-1:0] d);
    u_peer.wr_cycle(1'b0, d, WP);
  endtask : wr

  task automatic rd(input logic stb_n, input logic rrn);
    u_peer.rd_cycle(stb_n, rrn, RP);
  endtask : rd

  // modes only latch while the full reset pin is low
  task automatic fres(input logic f, i9, o9, b, s, input logic [2:0] idx);
    full_rst_n <= 1'b0;
    ft_si      <= f;
    in9        <= i9;
    out9       <= o9;
    order      <= b;
    flsync     <= s;
    {load_n, sel1, sel0} <= idx;
    repeat (10) @(posedge clk);
    full_rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    load_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : fres

  // offset readback alternates almost empty then almost full
  task automatic offs_check(input logic [WORD_W-1:0] e_ae, input logic [WORD_W-1:0] e_af);
    load_n <= 1'b0;
    rd(1'b0, 1'b1);
    chk_word(dout, e_ae);
    rd(1'b0, 1'b1);
    chk_word(dout, e_af);
  endtask : offs_check

  // ******
  // scenarios
  // ******
  task automatic t_reset_state();
    fres(0, 0, 0, 0, 0, 3'h0);
    chk_word(dout, '0);
    chk_flag(empty_n, 1'b0);
    chk_flag(full_n, 1'b1);
    chk_flag(half_n, 1'b1);
    chk_flag(aempty_n, 1'b0);
    chk_flag(afull_n, 1'b1);
    oe_in_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk_flag(oe_n, 1'b1);
    oe_in_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk_flag(oe_n, 1'b0);
  endtask : t_reset_state

  // reader stalls while the store fills, then drains it dry
  task automatic t_fill_drain();
    fres(0, 0, 0, 0, 0, 3'h0);
    for (int i = 0; i < 3; i++) wr(pat(i));
    chk_word(dout, '0);
    chk_flag(aempty_n, 1'b1);
    for (int i = 3; i < DEPTH_DEF; i++) wr(pat(i));
    chk_flag(full_n, 1'b0);
    chk_flag(half_n, 1'b0);
    chk_flag(afull_n, 1'b0);
    wr(18'h3ffff);
    for (int i = 0; i < DEPTH_DEF; i++) begin
      rd(1'b0, 1'b1);
      chk_word(dout, pat(i));
    end
    chk_flag(empty_n, 1'b0);
    chk_flag(aempty_n, 1'b0);
    chk_flag(afull_n, 1'b1);
    rd(1'b0, 1'b1);
    chk_word(dout, pat(DEPTH_DEF - 1));
  endtask : t_fill_drain

  task automatic t_fall_through();
    fres(1, 0, 0, 0, 0, 3'h0);
    chk_flag(empty_n, 1'b1);
    chk_flag(full_n, 1'b0);
    wr(pat(40));
    wr(pat(41));
    rd(1'b1, 1'b1);
    rd(1'b1, 1'b1);
    chk_word(dout, pat(40));
    chk_flag(empty_n, 1'b0);
    rd(1'b0, 1'b1);
    chk_word(dout, pat(41));
  endtask : t_fall_through

  task automatic t_widths();
    for (int b = 0; b < 2; b++) begin
      fres(0, 0, 1, b[0], 0, 3'h0);
      wr(W18);
      rd(1'b0, 1'b1);
      chk_word(dout, {9'h000, b[0] ? W18[8:0] : W18[17:9]});
      rd(1'b0, 1'b1);
      chk_word(dout, {9'h000, b[0] ? W18[17:9] : W18[8:0]});
      fres(0, 1, 0, b[0], 0, 3'h0);
      wr({9'h000, BA});
      wr({9'h000, BB});
      rd(1'b0, 1'b1);
      chk_word(dout, b[0] ? {BB, BA} : {BA, BB});
    end
  endtask : t_widths

  task automatic t_reread();
    for (int m = 0; m < 2; m++) begin
      rlat <= m[0];
      fres(0, 0, 0, 0, 0, 3'h0);
      for (int i = 50; i < 53; i++) wr(pat(i));
      rd(1'b0, 1'b1);
      rd(1'b0, 1'b1);
      chk_word(dout, pat(51));
      rd(1'b1, 1'b0);
      chk_word(dout, pat(m[0] ? 51 : 50));
      rd(1'b0, 1'b1);
      chk_word(dout, pat(m[0] ? 50 : 51));
    end
  endtask : t_reread

  task automatic t_offsets();
    for (int i = 0; i < NUM_DEF_OFFS; i++) begin
      fres(0, 0, 0, 0, 0, 3'(i));
      offs_check(WORD_W'(i + 1), WORD_W'(i + 1));
    end
    wr(18'h00005);
    wr(18'h00003);
    offs_check(18'h00005, 18'h00003);
    ser_n  <= 1'b0;
    for (int i = 9; i >= 0; i--) begin
      ft_si <= SER[i];
      u_peer.wr_cycle(1'b1, '0, WP);
    end
    ser_n <= 1'b1;
    offs_check(18'h00002, 18'h00006);
    load_n <= 1'b1;
    for (int i = 0; i < 3; i++) wr(pat(i));
    soft_rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    soft_rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk_flag(empty_n, 1'b0);
    chk_flag(aempty_n, 1'b0);
    offs_check(18'h00002, 18'h00006);
  endtask : t_offsets

  // synchronous almost empty must wait for a read clock edge
  task automatic t_sync_flags();
    fres(0, 0, 0, 0, 1, 3'h0);
    for (int i = 0; i < 3; i++) wr(pat(i));
    chk_flag(aempty_n, 1'b0);
    rd(1'b1, 1'b1);
    chk_flag(aempty_n, 1'b1);
  endtask : t_sync_flags

  task automatic end_of_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    clk = 1'b0; rst_n = 1'b0; oe_in_n = 1'b0; in9 = 1'b0; out9 = 1'b0; ft_si = 1'b0;
    sel0 = 1'b0; sel1 = 1'b0; load_n = 1'b1; ser_n = 1'b1; flsync = 1'b0;
    full_rst_n = 1'b0; soft_rst_n = 1'b1; order = 1'b0; rlat = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_state();
    t_fill_drain();
    t_fall_through();
    t_widths();
    t_reread();
    t_offsets();
    t_sync_flags();
    end_of_test();
  end

  // watchdog, about fifteen times the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

endmodule : dual_clock_bus_matching_fifo_bench

`default_nettype wire
